// ===== avg_pkg.sv
// shared constants for the reading post-processing block
package avg_pkg;
	// register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] COUNT_OFS = 8'h04;
	localparam logic [7:0] FUNC_OFS = 8'h08;
	localparam logic [7:0] SCALE_OFS = 8'h0C;
	localparam logic [7:0] OFFSET_OFS = 8'h10;
	localparam logic [7:0] STATUS_OFS = 8'h14;
	localparam logic [7:0] READING_OFS = 8'h18;
	localparam logic [7:0] NULLREF_OFS = 8'h1C;
	localparam logic [7:0] RATE_OFS = 8'h20;
	// register field positions
	localparam int CTRL_SMOOTH_BIT = 0;
	localparam int CTRL_KIND_BIT = 1;
	localparam int CTRL_MATH_BIT = 2;
	localparam int CTRL_RATE_LSB = 3;
	localparam int CTRL_NULL_BIT = 8;
	localparam int FUNC_RANGE_LSB = 8;
	localparam int STAT_FILL_LSB = 8;
	localparam int RATE_GATE_BIT = 16;
	localparam int RATE_BW_LSB = 20;
	// reset values
	localparam logic [6:0] COUNT_RST = 7'h0A;
	localparam logic [31:0] SCALE_RST = 32'h0000_0001;
	// measurement functions
	typedef enum logic [3:0] {
		F_DCV = 4'h0, F_ACV = 4'h1, F_DCI = 4'h2, F_ACI = 4'h3, F_RES2 = 4'h4,
		F_RES4 = 4'h5, F_FREQ = 4'h6, F_PER = 4'h7, F_CONT = 4'h8, F_DIODE = 4'h9
	} func_t;
	localparam int NUM_FUNC = 10;
	// rate settings
	typedef enum logic [1:0] {R_FAST = 2'h0, R_MED = 2'h1, R_SLOW = 2'h2} rate_t;
	// line cycle counts in tenths per rate
	localparam logic [6:0] LCC_FAST = 7'h01;
	localparam logic [6:0] LCC_MED = 7'h0A;
	localparam logic [6:0] LCC_SLOW = 7'h64;
	// lower ac bandwidth edge in hz per rate, upper edge fixed
	localparam logic [9:0] BW_FAST_HZ = 10'h1F4;
	localparam logic [9:0] BW_MED_HZ = 10'h032;
	localparam logic [9:0] BW_SLOW_HZ = 10'h005;
	localparam int BW_HIGH_HZ = 100000;
	// timing: one line cycle at 50 hz, one-second gate
	localparam int CLK_PERIOD_NS = 10;
	localparam int LINE_CYCLE_US = 20000;
	localparam int GATE_MS = 1000;
	localparam int LINE_CYCLE_CLKS = LINE_CYCLE_US * 1000 / CLK_PERIOD_NS;
	localparam int GATE_CLKS = GATE_MS * 1000000 / CLK_PERIOD_NS;
	// range limits in input units, range index 0 to 7
	localparam logic [7:0][31:0] RANGE_LIMIT = {
		32'h7FFF_FFFF, 32'h7FFF_FFFF, 32'h4786_8C00, 32'h0727_0E00,
		32'h00B7_1B00, 32'h0012_4F80, 32'h0001_D4C0, 32'h0000_2EE0
	};
endpackage

// ===== mean_divider.sv
// signed sum divided by an unsigned count, one quotient bit per clock
`timescale 1ns/1ps
module mean_divider #(
	parameter int SW = 39,
	parameter int CW = 7
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// request
	input wire logic start,
	input wire logic signed [SW-1:0] dividend,
	input wire logic [CW-1:0] divisor,
	// answer
	output logic done,
	output logic signed [SW-1:0] quotient
);
	// all divider state
	typedef struct packed {
		logic busy;
		logic done;
		logic neg;
		logic [5:0] cnt;
		logic [CW:0] rem;
		logic [SW-1:0] quo;
	} div_state_t;

	div_state_t q_q, q_d;
	logic [CW:0] trial;

	// the step counter is six bits wide, so longer sums cannot be served
	if (SW < 2 || SW > 63 || CW < 1)
		$error("SW must be 2 to 63 and CW at least 1");

	// restoring division on the magnitude, sign put back at the end
	always_comb
	begin
		q_d = q_q;
		q_d.done = 1'b0;
		trial = {q_q.rem[CW-1:0], q_q.quo[SW-1]};
		if (start)
		begin
			q_d.busy = 1'b1;
			q_d.neg = dividend[SW-1];
			q_d.quo = dividend[SW-1] ? -dividend : dividend;
			q_d.rem = '0;
			q_d.cnt = 6'(SW);
		end
		else if (q_q.busy)
		begin
			q_d.quo = {q_q.quo[SW-2:0], 1'b0};
			if (trial >= {1'b0, divisor})
			begin
				q_d.rem = trial - {1'b0, divisor};
				q_d.quo[0] = 1'b1;
			end
			else
				q_d.rem = trial;
			q_d.cnt = q_q.cnt - 6'h01;
			if (q_q.cnt == 6'h01)
			begin
				q_d.busy = 1'b0;
				q_d.done = 1'b1;
			end
		end
	end

	// state register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			q_q <= '0;
		else
			q_q <= q_d;
	end

	assign done = q_q.done;
	assign quotient = q_q.neg ? -q_q.quo : q_q.quo;
endmodule

// ===== reading_average_offset_rate.sv
// averaging, relative offset and rate selection for converter readings
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
// Summary of operation
// R01 - output is mean of 1 to 100 results
// R02 - averaging applies only while switched on
// R03 - off: each result passes straight through
// R04 - kind selects sliding window or block mean
// R05 - sliding: first mean once window holds count
// R06 - sliding: newest displaces oldest, one per result
// R07 - block: mean per count results, then restart
// R08 - indicator high while averaging is on
// R09 - no averaging for frequency, period, continuity, diode
// R10 - null on latches reading, later output subtracts it
// R11 - one null reference per function, all ranges
// R12 - overflow from raw input versus range limit
// R13 - null key toggles null, indicator shows it
// R14 - scale one plus offset gives manual null
// R15 - rate picks 0.1, 1 or 10 line cycles
// R16 - a line cycle lasts 20 ms at 50 Hz
// R17 - ac bandwidth low edge 500, 50, 5 Hz
// R18 - frequency, period gated 1 s; continuity fast; diode medium
module reading_average_offset_rate #(
	parameter int MAX_COUNT = 100,
	parameter int LINE_CYCLE_CLKS = avg_pkg::LINE_CYCLE_CLKS,
	parameter int GATE_CLKS = avg_pkg::GATE_CLKS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter results
	input wire logic conv_valid,
	input wire logic signed [31:0] conv_data,
	output logic conv_busy,
	// front panel key pin
	input wire logic null_key,
	// processed readings
	output logic reading_valid,
	output logic signed [31:0] reading_data,
	output logic reading_ovr,
	// indicators
	output logic smoothing_indicator,
	output logic null_indicator,
	// converter settings
	output logic [31:0] integ_clks,
	output logic [6:0] line_cycle_count,
	output logic [9:0] ac_bw_low_hz,
	output logic ac_bw_sel
);
	localparam int SW = 39;

	// refuse parameter values the datapath cannot serve
	if (MAX_COUNT < 1 || MAX_COUNT > 127)
		$error("MAX_COUNT must be 1 to 127");
	if (LINE_CYCLE_CLKS < 10 || LINE_CYCLE_CLKS > 200000000)
		$error("LINE_CYCLE_CLKS out of range");

	typedef enum logic [1:0] {S_IDLE = 2'b00, S_DIV = 2'b01, S_POST = 2'b10} st_t;

	// whole block state
	typedef struct packed {
		logic key_s1;
		logic key_s2;
		logic key_s3;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic smooth_on;
		logic kind;
		logic math_on;
		logic [1:0] rate;
		logic [6:0] cnt;
		logic [3:0] func;
		logic [2:0] rng;
		logic [31:0] m;
		logic [31:0] b;
		st_t st;
		logic [6:0] wptr;
		logic [6:0] fill;
		logic [SW-1:0] sum;
		logic [SW-1:0] dsum;
		logic div_go;
		logic [6:0] dcnt; // divisor held while a divide runs
		logic [31:0] mean;
		logic null_on;
		logic [avg_pkg::NUM_FUNC-1:0][31:0] refs;
		logic rd_v;
		logic [31:0] rd;
		logic rd_ovr;
		logic ovr_p; // raw overflow seen since the last reading
		logic [31:0] integ;
		logic [6:0] lcc;
		logic [9:0] bwl;
		logic ac;
	} state_t;

	state_t q_q, q_d;
	logic [1:0] rst_sync_q; // release synchroniser
	logic rst_n; // synchronised reset
	logic [31:0] win_mem [0:MAX_COUNT-1]; // sliding window store, no reset needed
	logic win_wr; // store newest result
	logic div_done;
	logic signed [SW-1:0] div_quo;
	logic excluded; // function that never averages
	logic key_press;
	logic wr_done; // write completes this edge
	logic toggle;
	logic clr; // settings changed, restart averaging
	logic signed [SW-1:0] x_ext;
	logic signed [SW-1:0] sum_new;
	logic signed [31:0] lim;
	logic signed [31:0] rel;
	logic signed [63:0] prod;
	logic [1:0] eff_rate;
	logic [6:0] fill_nx;

	// async assert, two-flop release
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	// mean of the collected results
	mean_divider #(.SW(SW), .CW(7)) u_div (
		.clk(core_clk),
		.rst_n(rst_n),
		.start(q_q.div_go),
		.dividend(q_q.dsum),
		.divisor(q_q.dcnt),
		.done(div_done),
		.quotient(div_quo)
	);

	// next-state logic for bus, settings, pipeline and rate
	always_comb
	begin
		q_d = q_q;
		q_d.pready = 1'b0;
		q_d.pslverr = 1'b0;
		q_d.div_go = 1'b0;
		q_d.rd_v = 1'b0;
		win_wr = 1'b0;
		sum_new = '0;
		fill_nx = q_q.fill + 7'h01;
		rel = '0;
		prod = '0;
		x_ext = {{(SW-32){conv_data[31]}}, conv_data};
		lim = signed'(avg_pkg::RANGE_LIMIT[q_q.rng]);
		excluded = q_q.func >= avg_pkg::F_FREQ; // [R09]
		// key pin: two flops, then edge detect on the second and third
		q_d.key_s1 = null_key;
		q_d.key_s2 = q_q.key_s1;
		q_d.key_s3 = q_q.key_s2;
		key_press = q_q.key_s2 & ~q_q.key_s3;
		wr_done = psel & penable & pwrite & q_q.pready & ~q_q.pslverr;
		toggle = key_press; // [R13]
		clr = 1'b0;

		// apb access phase: answer one cycle after penable rises
		if (psel && penable && !q_q.pready)
		begin
			q_d.pready = 1'b1;
			q_d.prdata = '0;
			case (paddr)
				avg_pkg::CTRL_OFS:
				begin
					q_d.prdata[avg_pkg::CTRL_SMOOTH_BIT] = q_q.smooth_on;
					q_d.prdata[avg_pkg::CTRL_KIND_BIT] = q_q.kind;
					q_d.prdata[avg_pkg::CTRL_MATH_BIT] = q_q.math_on;
					q_d.prdata[avg_pkg::CTRL_RATE_LSB +: 2] = q_q.rate;
				end
				avg_pkg::COUNT_OFS: q_d.prdata[6:0] = q_q.cnt;
				avg_pkg::FUNC_OFS:
				begin
					q_d.prdata[3:0] = q_q.func;
					q_d.prdata[avg_pkg::FUNC_RANGE_LSB +: 3] = q_q.rng;
				end
				avg_pkg::SCALE_OFS: q_d.prdata = q_q.m;
				avg_pkg::OFFSET_OFS: q_d.prdata = q_q.b;
				avg_pkg::STATUS_OFS:
				begin
					q_d.prdata[0] = q_q.smooth_on;
					q_d.prdata[1] = q_q.null_on;
					q_d.prdata[2] = q_q.rd_ovr;
					q_d.prdata[3] = q_q.st != S_IDLE;
					q_d.prdata[avg_pkg::STAT_FILL_LSB +: 7] = q_q.fill;
				end
				avg_pkg::READING_OFS: q_d.prdata = q_q.rd;
				avg_pkg::NULLREF_OFS: q_d.prdata = q_q.refs[q_q.func]; // [R11]
				avg_pkg::RATE_OFS:
				begin
					q_d.prdata[6:0] = q_q.lcc;
					q_d.prdata[avg_pkg::RATE_GATE_BIT] = q_q.func == avg_pkg::F_FREQ
						|| q_q.func == avg_pkg::F_PER;
					q_d.prdata[avg_pkg::RATE_BW_LSB +: 10] = q_q.bwl;
				end
				default: q_d.pslverr = 1'b1; // unmapped
			endcase
		end

		// register writes take effect at the completing edge
		if (wr_done)
		begin
			case (paddr)
				avg_pkg::CTRL_OFS:
				begin
					// averaging cannot be switched on for excluded functions
					q_d.smooth_on = pwdata[avg_pkg::CTRL_SMOOTH_BIT] & ~excluded; // [R02] [R09]
					q_d.kind = pwdata[avg_pkg::CTRL_KIND_BIT]; // [R04]
					q_d.math_on = pwdata[avg_pkg::CTRL_MATH_BIT];
					if (pwdata[avg_pkg::CTRL_RATE_LSB +: 2] != 2'b11)
						q_d.rate = pwdata[avg_pkg::CTRL_RATE_LSB +: 2];
					toggle = toggle | pwdata[avg_pkg::CTRL_NULL_BIT]; // [R13]
					clr = 1'b1;
				end
				avg_pkg::COUNT_OFS:
				begin
					// counts outside 1 to MAX_COUNT are ignored
					if (pwdata[31:0] >= 32'h1 && pwdata[31:0] <= 32'(MAX_COUNT))
						q_d.cnt = pwdata[6:0]; // [R01]
					clr = 1'b1;
				end
				avg_pkg::FUNC_OFS:
				begin
					if (pwdata[3:0] < 4'(avg_pkg::NUM_FUNC))
					begin
						q_d.func = pwdata[3:0];
						if (pwdata[3:0] >= avg_pkg::F_FREQ)
							q_d.smooth_on = 1'b0; // [R09]
					end
					q_d.rng = pwdata[avg_pkg::FUNC_RANGE_LSB +: 3];
					clr = 1'b1;
				end
				avg_pkg::SCALE_OFS: q_d.m = pwdata; // [R14]
				avg_pkg::OFFSET_OFS: q_d.b = pwdata; // [R14]
				default:
				begin
					// read-only or unmapped: nothing stored
				end
			endcase
		end

		// converter result pipeline
		case (q_q.st)
			S_IDLE:
			begin
				if (conv_valid)
				begin
					// overflow judged on the raw result, the reference plays no part
					// held back so the flag changes only with its own reading
					q_d.ovr_p = q_q.ovr_p | (conv_data > lim || conv_data < -lim); // [R12]
					if (!q_q.smooth_on)
					begin
						q_d.mean = conv_data; // [R03]
						q_d.st = S_POST;
					end
					else if (!q_q.kind)
					begin
						// sliding window: drop the oldest once full
						win_wr = 1'b1;
						sum_new = signed'(q_q.sum) + x_ext;
						if (q_q.fill == q_q.cnt)
							sum_new = sum_new - {{(SW-32){win_mem[q_q.wptr][31]}},
								win_mem[q_q.wptr]}; // [R06]
						else
							q_d.fill = fill_nx; // [R05]
						q_d.wptr = (q_q.wptr == q_q.cnt - 7'h01) ? 7'h00 : q_q.wptr + 7'h01;
						q_d.sum = sum_new;
						if (fill_nx >= q_q.cnt)
						begin
							// a mean for every result once the window is full
							q_d.dsum = sum_new; // [R05] [R06]
							q_d.dcnt = q_q.cnt; // a count write cannot upset this divide
							q_d.div_go = 1'b1;
							q_d.st = S_DIV;
						end
					end
					else
					begin
						// block: average then start from empty
						sum_new = signed'(q_q.sum) + x_ext;
						q_d.sum = sum_new;
						q_d.fill = fill_nx;
						if (fill_nx == q_q.cnt)
						begin
							q_d.dsum = sum_new; // [R07]
							q_d.dcnt = q_q.cnt;
							q_d.div_go = 1'b1;
							q_d.sum = '0; // [R07]
							q_d.fill = '0;
							q_d.st = S_DIV;
						end
					end
				end
			end
			S_DIV:
			begin
				if (div_done)
				begin
					q_d.mean = div_quo[31:0]; // [R01]
					q_d.st = S_POST;
				end
			end
			S_POST:
			begin
				// relative then scale and offset
				rel = q_q.null_on ? signed'(q_q.mean) - signed'(q_q.refs[q_q.func])
					: signed'(q_q.mean); // [R10] [R11]
				prod = signed'(q_q.m) * rel;
				q_d.rd = q_q.math_on ? prod[31:0] + q_q.b : rel; // [R14]
				q_d.rd_v = 1'b1;
				q_d.rd_ovr = q_q.ovr_p; // [R12]
				q_d.ovr_p = 1'b0;
				q_d.st = S_IDLE;
			end
			default: q_d.st = S_IDLE;
		endcase

		// a settings change restarts averaging; a running divide still finishes
		if (clr)
		begin
			q_d.sum = '0;
			q_d.fill = '0;
			q_d.wptr = '0;
		end

		// null switch: turning on latches the last unadjusted reading
		if (toggle)
		begin
			q_d.null_on = ~q_q.null_on; // [R13]
			if (!q_q.null_on)
				q_d.refs[q_q.func] = q_q.mean; // [R10] [R11]
		end

		// rate: fixed for continuity and diode, gated for frequency and period
		case (q_q.func)
			avg_pkg::F_CONT: eff_rate = avg_pkg::R_FAST; // [R18]
			avg_pkg::F_DIODE: eff_rate = avg_pkg::R_MED; // [R18]
			default: eff_rate = q_q.rate;
		endcase
		case (eff_rate)
			avg_pkg::R_FAST:
			begin
				q_d.integ = 32'(LINE_CYCLE_CLKS / 10); // [R15] [R16]
				q_d.lcc = avg_pkg::LCC_FAST;
				q_d.bwl = avg_pkg::BW_FAST_HZ; // [R17]
			end
			avg_pkg::R_MED:
			begin
				q_d.integ = 32'(LINE_CYCLE_CLKS); // [R15] [R16]
				q_d.lcc = avg_pkg::LCC_MED;
				q_d.bwl = avg_pkg::BW_MED_HZ; // [R17]
			end
			default:
			begin
				q_d.integ = 32'(LINE_CYCLE_CLKS * 10); // [R15] [R16]
				q_d.lcc = avg_pkg::LCC_SLOW;
				q_d.bwl = avg_pkg::BW_SLOW_HZ; // [R17]
			end
		endcase
		if (q_q.func == avg_pkg::F_FREQ || q_q.func == avg_pkg::F_PER)
		begin
			q_d.integ = 32'(GATE_CLKS); // [R18]
			q_d.lcc = '0;
		end
		q_d.ac = q_q.func == avg_pkg::F_ACV || q_q.func == avg_pkg::F_ACI; // [R17]
		if (!q_d.ac)
			q_d.bwl = '0;
	end

	// sliding window store write port
	always_ff @(posedge core_clk)
	begin
		if (win_wr)
			win_mem[q_q.wptr] <= conv_data; // [R06]
	end

	// state register; scale resets to one so math alone is an offset
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			q_q <= '0;
			q_q.cnt <= avg_pkg::COUNT_RST;
			q_q.m <= avg_pkg::SCALE_RST;
			q_q.rate <= avg_pkg::R_MED;
			q_q.st <= S_IDLE;
		end
		else
			q_q <= q_d;
	end

	// outputs straight from the state register
	assign prdata = q_q.prdata;
	assign pready = q_q.pready;
	assign pslverr = q_q.pslverr;
	assign conv_busy = q_q.st != S_IDLE;
	assign reading_valid = q_q.rd_v;
	assign reading_data = q_q.rd;
	assign reading_ovr = q_q.rd_ovr;
	assign smoothing_indicator = q_q.smooth_on; // [R08]
	assign null_indicator = q_q.null_on; // [R13]
	assign integ_clks = q_q.integ;
	assign line_cycle_count = q_q.lcc;
	assign ac_bw_low_hz = q_q.bwl;
	assign ac_bw_sel = q_q.ac;
endmodule

// ===== avg_props_properties.sv
// port checks for the reading averaging block
`timescale 1ns/1ps
module avg_props #(
	parameter int LINE_CYCLE_CLKS = 100,
	parameter int GATE_CLKS = 500
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic resetn,
	// bus handshake
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// streams
	input wire logic conv_valid,
	input wire logic conv_busy,
	input wire logic null_key,
	input wire logic reading_valid,
	input wire logic signed [31:0] reading_data,
	input wire logic reading_ovr,
	// indicators and settings
	input wire logic smoothing_indicator,
	input wire logic null_indicator,
	input wire logic [31:0] integ_clks,
	input wire logic [6:0] line_cycle_count,
	input wire logic [9:0] ac_bw_low_hz,
	input wire logic ac_bw_sel
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// result accepted by the block
	logic take;
	assign take = conv_valid && !conv_busy;
	property p_ready_pulse; pready |=> !pready; endproperty
	property p_err; pslverr |-> pready && psel && penable; endproperty
	property p_pass; take && !smoothing_indicator |=> conv_busy ##1 reading_valid; endproperty
	property p_avg_wait; take && smoothing_indicator |=> !reading_valid [*8]; endproperty
	property p_hold; !reading_valid |-> $stable(reading_data) && $stable(reading_ovr); endproperty
	property p_cause; reading_valid |-> $past(conv_busy); endproperty
	property p_key; $rose(null_key) |=> ##[1:4] $changed(null_indicator); endproperty
	property p_med; line_cycle_count == 7'h0A |-> integ_clks == LINE_CYCLE_CLKS; endproperty
	property p_fs;
		line_cycle_count == 7'h01 |-> integ_clks == LINE_CYCLE_CLKS / 10;
	endproperty
	property p_bw;
		ac_bw_sel |-> ac_bw_low_hz == (line_cycle_count == 7'h01 ? 10'h1F4 :
			line_cycle_count == 7'h0A ? 10'h032 : 10'h005);
	endproperty
	property p_gate;
		line_cycle_count == 7'h00 && integ_clks != 0 |-> integ_clks == GATE_CLKS;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
	a_err: assert property (p_err) else $error("pslverr outside answer");
	a_pass: assert property (p_pass) else $error("pass-through late");
	a_avg_wait: assert property (p_avg_wait) else $error("mean came too early");
	a_hold: assert property (p_hold) else $error("reading changed alone");
	a_cause: assert property (p_cause) else $error("reading without result");
	a_key: assert property (p_key) else $error("key did not toggle null");
	a_med: assert property (p_med) else $error("medium length wrong");
	a_fs: assert property (p_fs) else $error("fast length wrong");
	a_bw: assert property (p_bw) else $error("bandwidth edge wrong");
	a_gate: assert property (p_gate) else $error("gate length wrong");
	// main scenarios reached
	c_avg: cover property (reading_valid && smoothing_indicator);
	c_null: cover property (reading_valid && null_indicator);
	c_err: cover property (pslverr);
endmodule

// ===== conv_source.sv
// converter model offering one raw result at a time
`timescale 1ns/1ps
module conv_source (
	// clock
	input wire logic core_clk,
	// bench request
	input wire logic go,
	input wire logic signed [31:0] value,
	// converter side
	input wire logic conv_busy,
	output logic conv_valid,
	output logic signed [31:0] conv_data,
	output logic idle
);
	initial
	begin
		conv_valid = 1'b0;
		conv_data = 32'h0000_0000;
	end
	// result held until an edge with the block idle takes it
	always @(posedge core_clk)
	begin
		if (go)
		begin
			conv_valid <= 1'b1;
			conv_data <= value;
		end
		else if (conv_valid && !conv_busy)
		begin
			conv_valid <= 1'b0;
			conv_data <= ~conv_data; // released data shows no stale value
		end
	end
	assign idle = !conv_valid && !go;
endmodule

// ===== tb_top.sv
// self-checking bench for the reading block
`timescale 1ns/1ps
module tb_top;
	localparam int LCC = 100; // shortened line cycle
	localparam int GATE = 500; // shortened gate
	logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, integ_clks, r;
	logic pready, pslverr, conv_valid, conv_busy, null_key = 1'b0, reading_valid, reading_ovr;
	logic smoothing_indicator, null_indicator, ac_bw_sel, go = 1'b0, idle, e;
	logic signed [31:0] conv_data, reading_data, v, val = 32'h0;
	logic [6:0] line_cycle_count;
	logic [9:0] ac_bw_low_hz;
	int error_cnt = 0;
	int n_compared = 0;
	int gap = 3; // idle cycles after each result
	logic [32:0] expq[$]; // expected ovr and reading
	logic [15:0] lf = 16'h5414; // generator state
	int lcc_t[3] = '{1, 10, 100};
	int int_t[3] = '{LCC / 10, LCC, LCC * 10};
	int bw_t[3] = '{500, 50, 5};
	int fn_t[3] = '{6, 8, 9};
	int flc_t[3] = '{0, 1, 10};
	int fin_t[3] = '{GATE, LCC / 10, LCC};
	always #5 core_clk = ~core_clk;
	reading_average_offset_rate #(.LINE_CYCLE_CLKS(LCC), .GATE_CLKS(GATE)) dut (.core_clk,
		.resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.conv_valid, .conv_data, .conv_busy, .null_key, .reading_valid, .reading_data,
		.reading_ovr, .smoothing_indicator, .null_indicator, .integ_clks, .line_cycle_count,
		.ac_bw_low_hz, .ac_bw_sel);
	conv_source src (.core_clk, .go, .value(val), .conv_busy, .conv_valid, .conv_data, .idle);
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp_word(input string n, input logic [31:0] x, input logic [31:0] g);
		n_compared++;
		if (g !== x)
		begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic cmp_rd(input logic [32:0] x, input logic [32:0] g);
		n_compared++;
		if (g !== x)
		begin
			error_cnt++;
			$display("wrong value reading expected %h seen %h", x, g);
		end
	endtask
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// one bus transfer, held until pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 20 && pready !== 1'b1; i++)
			@(posedge core_clk);
		if (i == 20)
		begin
			error_cnt++;
			stop_test();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		cmp_word(n, x, r);
	endtask
	// one result through the converter model
	task automatic send(input logic signed [31:0] s);
		int i;
		val <= s;
		go <= 1'b1;
		@(posedge core_clk);
		go <= 1'b0;
		for (i = 0; i < 60 && idle !== 1'b1; i++)
			@(posedge core_clk);
		if (i == 60)
		begin
			error_cnt++;
			stop_test();
		end
		repeat (gap) @(posedge core_clk);
	endtask
	task automatic key();
		null_key <= 1'b1;
		repeat (4) @(posedge core_clk);
		null_key <= 1'b0;
		repeat (6) @(posedge core_clk);
	endtask
	// readings checked against the oldest note
	always @(posedge core_clk)
		if (reading_valid === 1'b1)
			cmp_rd(expq.size() > 0 ? expq.pop_front() : 33'bx, {reading_ovr, reading_data});
	initial
	begin
		repeat (100000) @(posedge core_clk);
		error_cnt++;
		stop_test();
	end
	initial
	begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		rd("count", avg_pkg::COUNT_OFS, 32'h0000_000A);
		rd("status", avg_pkg::STATUS_OFS, 32'h0000_0000);
		apb(1'b0, 8'hFC, 32'h0);
		cmp_word("slverr", 32'h1, 32'(e));
		cmp_word("integ", LCC, integ_clks);
		for (int k = 0; k < 8; k++)
		begin
			lf = lfsr(lf);
			v = {{16{lf[15]}}, lf};
			expq.push_back({v > 12000 || v < -12000, v});
			send(v);
		end
		wr(avg_pkg::COUNT_OFS, 32'h3);
		wr(avg_pkg::CTRL_OFS, 32'h9);
		gap = 44;
		cmp_word("smooth", 32'h1, 32'(smoothing_indicator));
		expq.push_back({1'b0, -32'sd1});
		expq.push_back({1'b0, -32'sd2});
		send(10);
		send(-20);
		send(5);
		send(7);
		wr(avg_pkg::COUNT_OFS, 32'h2);
		wr(avg_pkg::CTRL_OFS, 32'hB);
		expq.push_back({1'b0, 32'sd3});
		expq.push_back({1'b0, -32'sd3});
		send(3);
		send(4);
		send(-9);
		send(2);
		wr(avg_pkg::COUNT_OFS, 32'h65);
		rd("count", avg_pkg::COUNT_OFS, 32'h2);
		wr(avg_pkg::FUNC_OFS, 32'h6);
		wr(avg_pkg::CTRL_OFS, 32'h9);
		gap = 3;
		cmp_word("smooth", 32'h0, 32'(smoothing_indicator));
		expq.push_back({1'b0, 32'sd5});
		send(5);
		wr(avg_pkg::FUNC_OFS, 32'h0);
		wr(avg_pkg::CTRL_OFS, 32'h8);
		expq.push_back({1'b0, 32'sd100});
		send(100);
		key();
		cmp_word("null", 32'h1, 32'(null_indicator));
		expq.push_back({1'b0, 32'sd50});
		send(150);
		wr(avg_pkg::FUNC_OFS, 32'h200);
		expq.push_back({1'b0, 32'sd20});
		send(120);
		wr(avg_pkg::FUNC_OFS, 32'h2);
		expq.push_back({1'b0, 32'sd30});
		send(30);
		wr(avg_pkg::FUNC_OFS, 32'h0);
		expq.push_back({1'b1, 32'sd11950});
		send(12050);
		expq.push_back({1'b0, 32'sd11900});
		send(12000);
		wr(avg_pkg::OFFSET_OFS, 32'h7);
		wr(avg_pkg::CTRL_OFS, 32'h10C);
		cmp_word("null", 32'h0, 32'(null_indicator));
		expq.push_back({1'b0, 32'sd47});
		send(40);
		wr(avg_pkg::FUNC_OFS, 32'h1);
		for (int k = 0; k < 3; k++)
		begin
			wr(avg_pkg::CTRL_OFS, 32'(k << 3));
			repeat (2) @(posedge core_clk);
			cmp_word("lcc", lcc_t[k], 32'(line_cycle_count));
			cmp_word("integ", int_t[k], integ_clks);
			cmp_word("bw", bw_t[k], 32'(ac_bw_low_hz));
			cmp_word("bwsel", 32'h1, 32'(ac_bw_sel));
		end
		for (int k = 0; k < 3; k++)
		begin
			wr(avg_pkg::FUNC_OFS, fn_t[k]);
			repeat (2) @(posedge core_clk);
			cmp_word("lcc", flc_t[k], 32'(line_cycle_count));
			cmp_word("integ", fin_t[k], integ_clks);
			cmp_word("bwsel", 32'h0, 32'(ac_bw_sel));
		end
		cmp_word("left", 32'h0, expq.size());
		stop_test();
	end
endmodule
bind reading_average_offset_rate avg_props #(.LINE_CYCLE_CLKS(LINE_CYCLE_CLKS),
	.GATE_CLKS(GATE_CLKS)) u_props (.core_clk, .resetn, .psel, .penable, .pready, .pslverr,
	.conv_valid, .conv_busy, .null_key, .reading_valid, .reading_data, .reading_ovr,
	.smoothing_indicator, .null_indicator, .integ_clks, .line_cycle_count, .ac_bw_low_hz,
	.ac_bw_sel);
